// >>> pkg/trs_defs.svh
// Purpose: Offsets, field positions, codes and reset values of the trigger routing switch
// Assumes: Included by bare name; definitions only
// Notes:   Register offsets are byte addresses of 32-bit words
`ifndef TRS_DEFS_SVH
`define TRS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TRS_ADDR_W          8
`define TRS_OFS_CTRL        8'h00
`define TRS_OFS_SOFT        8'h04
`define TRS_OFS_ROUTE       8'h08
`define TRS_OFS_CLEAR       8'h0c
`define TRS_OFS_STATUS      8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRS_CTRL_OPEN_BIT   0
`define TRS_CTRL_CLOSE_BIT  1
`define TRS_SOFT_LEVEL_BIT  0
`define TRS_ROUTE_SRC_LSB   0
`define TRS_ROUTE_DST_LSB   8
`define TRS_ROUTE_MID_LSB   16
`define TRS_STAT_OPEN_BIT   0
`define TRS_STAT_NOINIT_BIT 1
`define TRS_STAT_PATH_BIT   2

// ----------------------------------------
// Selection codes
// ----------------------------------------
`define TRS_SEL_NOTHING     8'h00
`define TRS_SEL_FRONT       8'h02
`define TRS_SEL_SOFT        8'h03
`define TRS_SEL_LINE_FIRST  8'h6f
`define TRS_SEL_LINE_LAST   8'h76
`define TRS_LINES           8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRS_RST_SOFT        1'b0
`define TRS_RST_OPEN        1'b0

`endif

// >>> pkg/trs_pkg.sv
// Purpose: Types shared by the trigger routing switch files
// Assumes: Codes come from trs_defs.svh
// Notes:   One routing path travels as one struct
`include "trs_defs.svh"

package trs_pkg;

    typedef logic [7:0] trs_sel_t;

    typedef struct packed {
        trs_sel_t mid;
        trs_sel_t dst;
        trs_sel_t src;
    } trs_route_s;

    typedef struct packed {
        logic path_err;
        logic noinit_err;
        logic opened;
    } trs_status_s;

endpackage

// >>> logic/trs_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: One clock, synchronous active-high reset
// Notes:   Output follows only when stages two and three agree
module trs_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,   // System clock
    input  wire logic         srst,    // Synchronous reset
    input  wire logic [W-1:0] pin_in,  // Asynchronous pin levels
    output logic      [W-1:0] pin_sync // Filtered, synchronised levels
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg, s2_reg, s3_reg, f_reg;
            logic f_next;

            always_comb begin
                f_next = (s2_reg == s3_reg) ? s3_reg : f_reg;
            end

            always_ff @(posedge clock) begin
                if (srst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    f_reg  <= 1'b0;
                end else begin
                    s1_reg <= pin_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    f_reg  <= f_next;
                end
            end

            assign pin_sync[i] = f_reg;
        end
    endgenerate
endmodule

// >>> logic/trs_switch.sv
// Purpose: Trigger routing switch between front connector, software level and backplane lines
// Assumes: 125 MHz clock, plain register port, read data one cycle after the strobe
// Notes:   Notes on behaviour list follows
//
// Notes on behaviour
// - Software level drives low for 0, high for 1
// - Software level is low after reset
// - Source: front, software, or lines 0-7
// - Destination: front or lines 0-7 only
// - Clear disconnects every source from every destination
// - Active path reads back as source, destination, intermediate
// - Codes: none 0, front 2, soft 3, lines 111-118
// - Software level read returns present level
`include "trs_defs.svh"

module trs_switch
    import trs_pkg::*;
(
    input  wire logic                      clock,       // 125 MHz system clock
    input  wire logic                      srst,        // Synchronous reset, active high
    input  wire logic [`TRS_ADDR_W-1:0]    reg_addr,    // Register byte address
    input  wire logic [31:0]               reg_wdata,   // Register write data
    input  wire logic                      reg_wr,      // Write strobe
    input  wire logic                      reg_rd,      // Read strobe
    output logic      [31:0]               reg_rdata,   // Read data, cycle after strobe
    input  wire logic                      front_in,    // Front connector level in
    output logic                           front_out,   // Front connector level out
    output logic                           front_oe,    // Front connector drive enable
    input  wire logic [`TRS_LINES-1:0]     line_in,     // Backplane trigger lines in
    output logic      [`TRS_LINES-1:0]     line_out,    // Backplane trigger lines out
    output logic      [`TRS_LINES-1:0]     line_oe,     // Backplane trigger drive enables
    output logic                           soft_level   // Present software trigger level
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic                  front_sync;
    logic [`TRS_LINES-1:0] line_sync;

    trs_pin_sync #(.W(`TRS_LINES + 1)) u_sync (
        .clock    (clock),
        .srst     (srst),
        .pin_in   ({front_in, line_in}),
        .pin_sync ({front_sync, line_sync})
    );

    // ----------------------------------------
    // Code helpers
    // ----------------------------------------
    function automatic logic is_line(input trs_sel_t code);
        is_line = (code >= `TRS_SEL_LINE_FIRST) && (code <= `TRS_SEL_LINE_LAST);
    endfunction

    function automatic logic [2:0] line_idx(input trs_sel_t code);
        trs_sel_t diff;
        diff     = code - `TRS_SEL_LINE_FIRST;
        line_idx = diff[2:0];
    endfunction

    function automatic logic path_ok(input trs_route_s r);
        logic src_ok, dst_ok, mid_ok;
        src_ok = (r.src == `TRS_SEL_FRONT) || (r.src == `TRS_SEL_SOFT)
                 || is_line(r.src);
        dst_ok = (r.dst == `TRS_SEL_FRONT) || is_line(r.dst);
        if ((r.src == `TRS_SEL_SOFT) && (r.dst == `TRS_SEL_FRONT)) begin
            mid_ok = is_line(r.mid);
        end else begin
            mid_ok = (r.mid == `TRS_SEL_NOTHING);
        end
        // A source looping onto itself would latch the line
        path_ok = src_ok && dst_ok && mid_ok && (r.src != r.dst);
    endfunction

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    trs_route_s  route_reg, route_next;
    trs_status_s stat_reg,  stat_next;
    logic        soft_reg,  soft_next;
    logic [31:0] rdata_reg, rdata_next;

    always_comb begin
        trs_route_s req;
        logic       ok_access;
        req        = reg_wdata[23:0];
        route_next = route_reg;
        stat_next  = stat_reg;
        soft_next  = soft_reg;
        rdata_next = 32'h0000_0000;
        ok_access  = stat_reg.opened || (reg_addr == `TRS_OFS_CTRL)
                     || (reg_addr == `TRS_OFS_STATUS);

        // Write-one-to-clear first so a same-cycle set wins below
        if (reg_wr && (reg_addr == `TRS_OFS_STATUS)) begin
            if (reg_wdata[`TRS_STAT_NOINIT_BIT]) stat_next.noinit_err = 1'b0;
            if (reg_wdata[`TRS_STAT_PATH_BIT])   stat_next.path_err   = 1'b0;
        end

        if ((reg_wr || reg_rd) && !ok_access) begin
            stat_next.noinit_err = 1'b1;
        end else if (reg_wr) begin
            case (reg_addr)
                `TRS_OFS_CTRL: begin
                    if (reg_wdata[`TRS_CTRL_OPEN_BIT]) begin
                        stat_next.opened = 1'b1;
                    end else if (reg_wdata[`TRS_CTRL_CLOSE_BIT]) begin
                        stat_next.opened = 1'b0;
                    end
                end
                `TRS_OFS_SOFT: soft_next = reg_wdata[`TRS_SOFT_LEVEL_BIT];
                `TRS_OFS_ROUTE: begin
                    if (path_ok(req)) begin
                        route_next = req;
                    end else begin
                        // Bad path leaves the active one untouched
                        stat_next.path_err = 1'b1;
                    end
                end
                `TRS_OFS_CLEAR: begin
                    route_next = '{`TRS_SEL_NOTHING, `TRS_SEL_NOTHING,
                                   `TRS_SEL_NOTHING};
                end
                default: ;
            endcase
        end

        if (reg_rd && ok_access) begin
            case (reg_addr)
                `TRS_OFS_SOFT:   rdata_next[`TRS_SOFT_LEVEL_BIT] = soft_reg;
                `TRS_OFS_ROUTE:  rdata_next[23:0] = route_reg;
                `TRS_OFS_STATUS: rdata_next[2:0]  = stat_reg;
                default:         rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            route_reg <= '{`TRS_SEL_NOTHING, `TRS_SEL_NOTHING, `TRS_SEL_NOTHING};
            stat_reg  <= '{1'b0, 1'b0, `TRS_RST_OPEN};
            soft_reg  <= `TRS_RST_SOFT;
            rdata_reg <= 32'h0000_0000;
        end else begin
            route_reg <= route_next;
            stat_reg  <= stat_next;
            soft_reg  <= soft_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Routing fabric
    // ----------------------------------------
    logic                  src_val;
    logic                  fout_next, foe_next;
    logic [`TRS_LINES-1:0] lout_next, loe_next;
    logic                  fout_reg,  foe_reg;
    logic [`TRS_LINES-1:0] lout_reg,  loe_reg;

    always_comb begin
        src_val   = 1'b0;
        fout_next = 1'b0;
        foe_next  = 1'b0;
        lout_next = '0;
        loe_next  = '0;
        if (route_reg.src == `TRS_SEL_FRONT) begin
            src_val = front_sync;
        end else if (route_reg.src == `TRS_SEL_SOFT) begin
            src_val = soft_reg;
        end else if (is_line(route_reg.src)) begin
            src_val = line_sync[line_idx(route_reg.src)];
        end

        if (route_reg.dst == `TRS_SEL_FRONT) begin
            foe_next  = 1'b1;
            fout_next = src_val;
            if (is_line(route_reg.mid)) begin
                // Software level drives its backplane line too; the front is driven with it directly
                loe_next[line_idx(route_reg.mid)]  = 1'b1;
                lout_next[line_idx(route_reg.mid)] = src_val;
            end
        end else if (is_line(route_reg.dst)) begin
            loe_next[line_idx(route_reg.dst)]  = 1'b1;
            lout_next[line_idx(route_reg.dst)] = src_val;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fout_reg <= 1'b0;
            foe_reg  <= 1'b0;
            lout_reg <= '0;
            loe_reg  <= '0;
        end else begin
            fout_reg <= fout_next;
            foe_reg  <= foe_next;
            lout_reg <= lout_next;
            loe_reg  <= loe_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign front_out  = fout_reg;
    assign front_oe   = foe_reg;
    assign line_out   = lout_reg;
    assign line_oe    = loe_reg;
    assign soft_level = soft_reg;

endmodule

// >>> sim/trs_switch_props.sv
// Purpose: Port checks of the trigger routing switch
// Assumes: Bound to trs_switch; one clock, sync reset
// Notes:   Open state is tracked here from control writes
`include "trs_defs.svh"
module trs_switch_props (
    input wire logic [0:0]              clock,      // System clock
    input wire logic                    srst,       // Sync reset
    input wire logic [`TRS_ADDR_W-1:0]  reg_addr,   // Address
    input wire logic [31:0]             reg_wdata,  // Write data
    input wire logic                    reg_wr,     // Write strobe
    input wire logic                    reg_rd,     // Read strobe
    input wire logic [31:0]             reg_rdata,  // Read data
    input wire logic                    front_oe,   // Front enable
    input wire logic [`TRS_LINES-1:0]   line_oe,    // Line enables
    input wire logic                    soft_level  // Software level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic open_reg;
    logic open_next;
    always_comb begin
        open_next = open_reg;
        if (reg_wr && reg_addr == `TRS_OFS_CTRL) begin
            open_next = reg_wdata[0] | (open_reg & ~reg_wdata[1]);
        end
    end
    always_ff @(posedge clock) begin
        open_reg <= srst ? 1'b0 : open_next;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    AST_SOFT_RESET: assert property ($past(srst) |-> !soft_level)
        else $error("soft level high after reset");
    AST_PINS_RESET: assert property ($past(srst) |-> line_oe == 8'h00 && !front_oe)
        else $error("pins driven after reset");
    AST_SOFT_WRITE: assert property (open_reg && reg_wr && reg_addr == `TRS_OFS_SOFT
        |-> ##2 soft_level == $past(reg_wdata[0], 2)) else $error("soft level not written");
    AST_SOFT_READ: assert property (open_reg && reg_rd && reg_addr == `TRS_OFS_SOFT
        |=> reg_rdata == {31'h0, soft_level}) else $error("soft level read wrong");
    AST_NOINIT: assert property (!open_reg && reg_rd && reg_addr != `TRS_OFS_STATUS
        |=> reg_rdata == 32'h0) else $error("read served before open");
    AST_SRC_CODES: assert property (reg_rd && reg_addr == `TRS_OFS_ROUTE
        |=> reg_rdata[7:0] inside {8'h00, 8'h02, 8'h03, [8'h6f:8'h76]})
        else $error("bad source code");
    AST_DST_CODES: assert property (reg_rd && reg_addr == `TRS_OFS_ROUTE
        |=> reg_rdata[15:8] inside {8'h00, 8'h02, [8'h6f:8'h76]}) else $error("bad dest code");
    AST_MID_CODES: assert property (reg_rd && reg_addr == `TRS_OFS_ROUTE
        |=> ((reg_rdata[15:0] == 16'h0203) ? reg_rdata[23:16] inside {[8'h6f:8'h76]}
        : reg_rdata[23:16] == 8'h00)) else $error("bad intermediate code");
    AST_CLEAR_PINS: assert property (open_reg && reg_wr && reg_addr == `TRS_OFS_CLEAR
        |-> ##2 (line_oe == 8'h00 && !front_oe)) else $error("clear left a path");
    AST_ONE_LINE: assert property ($onehot0(line_oe))
        else $error("several lines driven");
endmodule

// >>> sim/trs_far_side.sv
// Purpose: Backplane lines and front connector beyond the switch
// Assumes: Bench sets the far-side levels
// Notes:   A driven wire shows the switch level, else the far level
module trs_far_side (
    input wire logic       front_out, // Switch front level
    input wire logic       front_oe,  // Switch drives front
    input wire logic [7:0] line_out,  // Switch line levels
    input wire logic [7:0] line_oe,   // Switch drives lines
    input wire logic       far_front, // Far front level
    input wire logic [7:0] far_line,  // Far line levels
    output logic           front_in,  // Resolved front wire
    output logic     [7:0] line_in    // Resolved line wires
);
    timeunit 1ns;
    timeprecision 1ps;
    assign front_in = front_oe ? front_out : far_front;
    assign line_in  = (line_oe & line_out) | (~line_oe & far_line);
endmodule

// >>> sim/trs_switch_test.sv
// Purpose: Self-checking bench of the trigger routing switch
// Assumes: 125 MHz clock, plain register port
// Notes:   Strobes keep one idle cycle between accesses
`include "trs_defs.svh"
module trs_switch_test
    import trs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, far_front = 1'b0;
    logic        front_in, front_out, front_oe, soft_level;
    logic [7:0]  reg_addr = 8'h00, far_line = 8'h00, line_in, line_out, line_oe;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    int          failures = 0, comparisons = 0;
    trs_route_s  good;
    trs_switch uut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .front_in(front_in),
        .front_out(front_out), .front_oe(front_oe), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .soft_level(soft_level));
    trs_far_side far (.front_out(front_out), .front_oe(front_oe), .line_out(line_out),
        .line_oe(line_oe), .far_front(far_front), .far_line(far_line), .front_in(front_in),
        .line_in(line_in));
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rd_val = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_reset_and_refuse();
        chk({31'h0, soft_level}, 32'h0);
        chk({23'h0, line_oe, front_oe}, 32'h0);
        wr(`TRS_OFS_SOFT, 32'h1);
        wr(`TRS_OFS_ROUTE, 32'h00006f02);
        rd(`TRS_OFS_SOFT);
        chk(rd_val, 32'h0);
        rd(`TRS_OFS_STATUS);
        chk(rd_val, 32'h2);
        wr(`TRS_OFS_STATUS, 32'h2);
        wr(`TRS_OFS_CTRL, 32'h1);
        rd(`TRS_OFS_ROUTE);
        chk(rd_val, 32'h0);
    endtask
    task automatic t_soft();
        for (int v = 1; v >= 0; v--) begin
            wr(`TRS_OFS_SOFT, v);
            repeat (3) @(posedge clock);
            chk({31'h0, soft_level}, v);
            rd(`TRS_OFS_SOFT);
            chk(rd_val, v);
        end
    endtask
    task automatic t_lines();
        for (int j = 0; j < 8; j++) begin
            @(posedge clock);
            far_front   <= j[0];
            far_line[j] <= ~j[0];
            wr(`TRS_OFS_ROUTE, {16'h0, 8'h6f + 8'(j), 8'h02});
            rd(`TRS_OFS_ROUTE);
            chk(rd_val, {16'h0, 8'h6f + 8'(j), 8'h02});
            repeat (8) @(posedge clock);
            chk({24'h0, line_oe}, 32'h1 << j);
            chk({31'h0, line_out[j]}, j[0]);
            wr(`TRS_OFS_ROUTE, {16'h02, 8'h6f + 8'(j)});
            repeat (8) @(posedge clock);
            chk({23'h0, line_oe, front_oe}, 32'h1);
            chk({31'h0, front_out}, !j[0]);
        end
    endtask
    logic [31:0] bad_tab [4] = '{32'h00000203, 32'h00000302, 32'h00706f03, 32'h00000201};
    task automatic t_soft_mid();
        wr(`TRS_OFS_SOFT, 32'h1);
        for (int k = 0; k < 8; k += 7) begin
            good = '{mid: 8'h6f + 8'(k), dst: `TRS_SEL_FRONT, src: `TRS_SEL_SOFT};
            wr(`TRS_OFS_ROUTE, {8'h0, good});
            repeat (4) @(posedge clock);
            chk({22'h0, line_oe, front_oe, front_out}, {22'h0, 8'h1 << k, 2'b11});
            chk({31'h0, line_out[k]}, 32'h1);
        end
        foreach (bad_tab[i]) begin
            wr(`TRS_OFS_ROUTE, bad_tab[i]);
            rd(`TRS_OFS_ROUTE);
            chk(rd_val, {8'h0, good});
            rd(`TRS_OFS_STATUS);
            chk(rd_val, 32'h5);
            wr(`TRS_OFS_STATUS, 32'h4);
        end
    endtask
    task automatic t_clear();
        wr(`TRS_OFS_CLEAR, 32'h0);
        rd(`TRS_OFS_ROUTE);
        chk(rd_val, 32'h0);
        chk({23'h0, line_oe, front_oe}, 32'h0);
    endtask
    // Close keeps the path; a mid-run reset must drop level, path and open state
    task automatic t_close_and_reset();
        wr(`TRS_OFS_ROUTE, 32'h00006f02);
        wr(`TRS_OFS_CTRL, 32'h2);
        rd(`TRS_OFS_SOFT);
        chk(rd_val, 32'h0);
        rd(`TRS_OFS_STATUS);
        chk(rd_val, 32'h2);
        chk({23'h0, line_oe, front_oe}, 32'h2);
        @(posedge clock);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        chk({31'h0, soft_level}, 32'h0);
        chk({23'h0, line_oe, front_oe}, 32'h0);
        rd(`TRS_OFS_STATUS);
        chk(rd_val, 32'h0);
        wr(`TRS_OFS_CTRL, 32'h1);
        rd(`TRS_OFS_ROUTE);
        chk(rd_val, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        t_reset_and_refuse();
        t_soft();
        t_lines();
        t_soft_mid();
        t_clear();
        t_close_and_reset();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end
endmodule
bind trs_switch trs_switch_props chk_i (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .front_oe(front_oe), .line_oe(line_oe), .soft_level(soft_level));
